// file: rtl/tsdc_pkg.sv
// Package for the TFT source driver data capture block.
// Assumes one 50 MHz system clock; all panel pins arrive asynchronously.
package tsdc_pkg;

   // Pixel and line geometry
   localparam int unsigned DATA_W     = 6;
   localparam int unsigned NUM_CH     = 3;
   localparam int unsigned NUM_POS    = 120;
   localparam int unsigned POS_W      = 7;
   localparam int unsigned MSB_BIT    = 5;
   localparam logic [6:0]  SKIP_FIRST = 7'h36;
   localparam logic [6:0]  SKIP_LEN   = 7'h0C;
   localparam logic [6:0]  SKIP_END   = 7'h42;
   localparam logic [6:0]  LAST_POS   = 7'h77;
   localparam logic [6:0]  LINE_FULL  = 7'h78;
   localparam logic [6:0]  LINE_SHORT = 7'h6C;
   localparam logic [1:0]  CARRY_LEN  = 2'h2;

   // Channel indices
   localparam int unsigned CH_RED   = 0;
   localparam int unsigned CH_GREEN = 1;
   localparam int unsigned CH_BLUE  = 2;

   // Register map (byte addresses, word index in adr[3:2])
   localparam int unsigned ADDR_W      = 4;
   localparam logic [1:0]  IDX_CTRL    = 2'h0;
   localparam logic [1:0]  IDX_STATUS  = 2'h1;
   localparam int unsigned CTRL_DIR    = 0;
   localparam int unsigned CTRL_COUNT  = 1;
   localparam int unsigned CTRL_FORMAT = 2;
   localparam logic [2:0]  CTRL_RESET  = 3'h3;
   localparam int unsigned ST_BUSY     = 0;
   localparam int unsigned ST_CARRY    = 1;
   localparam int unsigned ST_HIZ      = 2;
   localparam int unsigned ST_TEST     = 3;
   localparam int unsigned ST_IDX_LSB  = 8;

   // Panel pins that travel together through the synchroniser
   typedef struct packed {
      logic [DATA_W-1:0] red;
      logic [DATA_W-1:0] green;
      logic [DATA_W-1:0] blue;
      logic              start_r;
      logic              start_l;
      logic              load;
      logic              invert;
      logic              power_save;
      logic              test_n;
      logic              shift_clk;
   } tsdc_pins_type;

   typedef enum logic [0:0] {
      ST_IDLE,
      ST_CAPTURE
   } tsdc_state_type;

endpackage : tsdc_pkg

// file: rtl/tsdc_capture.sv
// Source driver front end: pixel capture, line latch and cascade carry.
// Assumes panel pins are asynchronous to clk_i and that the shift clock
// runs well below half of clk_i; configuration comes over Wishbone.
//
// Functional notes
// - Gray-scale: six bits per channel, bit 5 most significant.
// - Binary: only bit 5 used per channel, lower bits ignored.
// - Direction high: right pin starts, left carries; low swaps roles.
// - Direction high fills positions 1 to 120; low fills 120 to 1.
// - Shift clock rising edge advances position and captures one pixel.
// - Load high at shift edge copies captured line to drive outputs.
// - Inversion input high reverses the data to rail mapping.
// - Count select low: 324 outputs, positions 55 to 66 disabled.
// - Format high: binary, converters off; low: gray scale, on.
// - Gray gives 64-level outputs; binary gives two-level outputs.
// - Power save at shift edge floats outputs and cuts current.
// - Test input low selects test mode; controller holds it high.
// - One pixel per clock; 120 or 108 clocks, skipping 55 to 66.
// - After the last capture, stop until a new start pulse.
// - Inversion change applies to the pixel captured that cycle.
// - Capture starts one shift cycle after the start pulse.
// - Carry rises one cycle before last capture, lasts two cycles.
// - Format change floats outputs for one shift cycle.
//
// The Wishbone interface to the registers and the register offsets were decided locally.
`timescale 1ns/100ps
module tsdc_capture
   import tsdc_pkg::*;
(
   input  wire logic                        clk_i,
   input  wire logic                        rst_i,
   // Wishbone classic slave
   input  wire logic                        wb_cyc_i,
   input  wire logic                        wb_stb_i,
   input  wire logic                        wb_we_i,
   input  wire logic [ADDR_W-1:0]           wb_adr_i,
   input  wire logic [3:0]                  wb_sel_i,
   input  wire logic [31:0]                 wb_dat_i,
   output logic      [31:0]                 wb_dat_o,
   output logic                             wb_ack_o,
   // Panel timing controller side
   input  wire logic [DATA_W-1:0]           red_channel_bus_i,
   input  wire logic [DATA_W-1:0]           green_channel_bus_i,
   input  wire logic [DATA_W-1:0]           blue_channel_bus_i,
   input  wire logic                        shift_clock_i,
   input  wire logic                        line_load_strobe_i,
   input  wire logic                        polarity_invert_i,
   input  wire logic                        power_save_input_i,
   input  wire logic                        test_mode_n_i,
   input  wire logic                        right_start_pulse_i,
   output logic                             right_start_pulse_o,
   output logic                             right_start_pulse_oe_o,
   input  wire logic                        left_start_pulse_i,
   output logic                             left_start_pulse_o,
   output logic                             left_start_pulse_oe_o,
   // Converter side
   output logic [NUM_POS-1:0][DATA_W-1:0]   red_drive_outputs_o,
   output logic [NUM_POS-1:0][DATA_W-1:0]   green_drive_outputs_o,
   output logic [NUM_POS-1:0][DATA_W-1:0]   blue_drive_outputs_o,
   output logic [NUM_POS-1:0]               pos_enable_o,
   output logic                             drive_hiz_o,
   output logic                             dac_enable_o,
   output logic                             test_active_o
);

   tsdc_pins_type                          pins_raw;
   tsdc_pins_type                          sync1_q;
   tsdc_pins_type                          sync2_q;
   logic                                   shift_prev_q;
   logic                                   start_prev_q;
   tsdc_state_type                         state_q;
   logic [POS_W-1:0]                       idx_q;
   logic                                   carry_q;
   logic [1:0]                             carry_cnt_q;
   logic                                   ps_q;
   logic                                   fmt_prev_q;
   logic                                   fmt_hiz_q;
   logic [2:0]                             ctrl_q;
   logic                                   ack_q;
   logic [31:0]                            rdata_q;
   logic [NUM_CH-1:0][NUM_POS-1:0][DATA_W-1:0] line_q;
   logic [NUM_CH-1:0][NUM_POS-1:0][DATA_W-1:0] drv_q;
   logic [NUM_POS-1:0]                     pos_en_q;
   logic                                   hiz_q;
   logic                                   dac_q;
   logic                                   test_q;
   logic                                   r_oe_q;
   logic                                   l_oe_q;

   // Pins enter as one bundle so all bits see the same latency
   assign pins_raw = '{red: red_channel_bus_i, green: green_channel_bus_i,
                       blue: blue_channel_bus_i,
                       start_r: right_start_pulse_i,
                       start_l: left_start_pulse_i,
                       load: line_load_strobe_i,
                       invert: polarity_invert_i,
                       power_save: power_save_input_i,
                       test_n: test_mode_n_i,
                       shift_clk: shift_clock_i};

   always_ff @(posedge clk_i) begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
   end

   // Configuration decode
   wire dir_right = ctrl_q[CTRL_DIR];
   wire count_360 = ctrl_q[CTRL_COUNT];
   wire fmt_bin   = ctrl_q[CTRL_FORMAT];

   wire shift_en = sync2_q.shift_clk & ~shift_prev_q;

   wire start_lvl  = dir_right ? sync2_q.start_r : sync2_q.start_l;
   // Only the first cycle of a two-cycle carry counts
   wire start_rise = start_lvl & ~start_prev_q;

   wire [POS_W-1:0] line_len  = count_360 ? LINE_FULL : LINE_SHORT;
   wire             capturing = (state_q == ST_CAPTURE);
   wire             last_cap  = capturing & (idx_q == line_len - 7'h01);

   wire [POS_W-1:0] pos_lin = (!count_360 && idx_q >= SKIP_FIRST)
                              ? idx_q + SKIP_LEN : idx_q;
   wire [POS_W-1:0] pos     = dir_right ? pos_lin : LAST_POS - pos_lin;

   // writes only while a position is active
   wire cap_we = shift_en & capturing;

   // inversion level sampled with the same pixel
   wire [DATA_W-1:0] inv_mask = {DATA_W{sync2_q.invert}};
   // full code; binary keeps only the top bit
   wire [DATA_W-1:0] bin_mask = fmt_bin ? (DATA_W'(1) << MSB_BIT)
                                        : {DATA_W{1'b1}};
   wire [NUM_CH-1:0][DATA_W-1:0] cap_val;
   assign cap_val[CH_RED]   = (sync2_q.red   ^ inv_mask) & bin_mask;
   assign cap_val[CH_GREEN] = (sync2_q.green ^ inv_mask) & bin_mask;
   assign cap_val[CH_BLUE]  = (sync2_q.blue  ^ inv_mask) & bin_mask;

   // load copies the latched line; test mode shows it live
   wire load_now = (shift_en & sync2_q.load) | ~sync2_q.test_n;

   wire fmt_chg = fmt_bin ^ fmt_prev_q;

   // power save acts at its own edge, not one later
   wire ps_now  = shift_en ? sync2_q.power_save : ps_q;

   // Sequencer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         shift_prev_q <= 1'b0;
         start_prev_q <= 1'b0;
         state_q      <= ST_IDLE;
         idx_q        <= '0;
      end else begin
         shift_prev_q <= sync2_q.shift_clk;
         if (shift_en) begin
            start_prev_q <= start_lvl;
            unique case (state_q)
               // first capture one cycle after start
               ST_IDLE: begin
                  if (start_rise) begin
                     state_q <= ST_CAPTURE;
                     idx_q   <= '0;
                  end
               end
               ST_CAPTURE: begin
                  if (last_cap) begin
                     state_q <= ST_IDLE;
                  end
                  idx_q <= idx_q + 7'h01;
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         carry_q     <= 1'b0;
         carry_cnt_q <= '0;
      end else if (shift_en) begin
         if (capturing && idx_q == line_len - 7'h02) begin
            carry_q     <= 1'b1;
            carry_cnt_q <= CARRY_LEN - 2'h1;
         end else if (carry_cnt_q != '0) begin
            carry_cnt_q <= carry_cnt_q - 2'h1;
         end else begin
            carry_q <= 1'b0;
         end
      end
   end

   // power save sampled at shift edge
   // format change floats outputs for one shift cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ps_q       <= 1'b0;
         fmt_prev_q <= CTRL_RESET[CTRL_FORMAT];
         fmt_hiz_q  <= 1'b0;
      end else begin
         fmt_prev_q <= fmt_bin;
         if (shift_en) begin
            ps_q <= sync2_q.power_save;
         end
         // Change wins over the clearing edge
         if (fmt_chg) begin
            fmt_hiz_q <= 1'b1;
         end else if (shift_en) begin
            fmt_hiz_q <= 1'b0;
         end
      end
   end

   // Line buffer and drive latches, one entry per channel and position
   for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      for (genvar p = 0; p < NUM_POS; p++) begin : g_pos
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               line_q[c][p] <= '0;
               drv_q[c][p]  <= '0;
            end else begin
               if (cap_we && pos == POS_W'(p)) begin
                  line_q[c][p] <= cap_val[c];
               end
               if (load_now) begin
                  drv_q[c][p] <= line_q[c][p];
               end
            end
         end
      end
   end

   // short mode disables the middle positions
   for (genvar p = 0; p < NUM_POS; p++) begin : g_en
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            pos_en_q[p] <= 1'b0;
         end else begin
            pos_en_q[p] <= count_360 || POS_W'(p) < SKIP_FIRST
                           || POS_W'(p) >= SKIP_END;
         end
      end
   end

   // Output status flops
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hiz_q  <= 1'b1;
         dac_q  <= 1'b0;
         test_q <= 1'b0;
         r_oe_q <= 1'b0;
         l_oe_q <= 1'b0;
      end else begin
         hiz_q  <= ps_now | fmt_chg | (fmt_hiz_q & ~shift_en);
         dac_q  <= ~fmt_bin & ~ps_now;
         test_q <= ~sync2_q.test_n;
         // carry pin is the non-start side
         r_oe_q <= ~dir_right;
         l_oe_q <= dir_right;
      end
   end

   // Wishbone classic slave, one wait state
   wire bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
   // Write lands on the edge where the master sees ack
   wire bus_end = wb_cyc_i & wb_stb_i & ack_q;
   wire wr_ctrl = bus_end & wb_we_i & wb_sel_i[0]
                  & (wb_adr_i[3:2] == IDX_CTRL);
   wire [31:0] status_word = {17'h00000, idx_q, 4'h0, test_q, hiz_q,
                              carry_q, capturing};
   wire [31:0] rd_mux = (wb_adr_i[3:2] == IDX_CTRL)   ? {29'h0, ctrl_q} :
                        (wb_adr_i[3:2] == IDX_STATUS) ? status_word :
                                                        32'h00000000;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q  <= CTRL_RESET;
         ack_q   <= 1'b0;
         rdata_q <= '0;
      end else begin
         ack_q <= bus_req;
         if (bus_req) begin
            rdata_q <= rd_mux;
         end
         if (wr_ctrl) begin
            ctrl_q <= wb_dat_i[2:0];
         end
      end
   end

   assign wb_ack_o               = ack_q;
   assign wb_dat_o               = rdata_q;
   assign right_start_pulse_o    = carry_q;
   assign left_start_pulse_o     = carry_q;
   assign right_start_pulse_oe_o = r_oe_q;
   assign left_start_pulse_oe_o  = l_oe_q;
   assign red_drive_outputs_o    = drv_q[CH_RED];
   assign green_drive_outputs_o  = drv_q[CH_GREEN];
   assign blue_drive_outputs_o   = drv_q[CH_BLUE];
   assign pos_enable_o           = pos_en_q;
   assign drive_hiz_o            = hiz_q;
   assign dac_enable_o           = dac_q;
   assign test_active_o          = test_q;

   // Assertions
   a_idx_in_line: assert property (@(posedge clk_i) disable iff (rst_i)
      capturing |-> idx_q < line_len)
      else $error("capture index beyond line length");

   a_line_stop: assert property (@(posedge clk_i) disable iff (rst_i)
      shift_en && last_cap |=> state_q == ST_IDLE)
      else $error("capture did not stop after last pixel");

   a_start_delay: assert property (@(posedge clk_i) disable iff (rst_i)
      shift_en && !capturing && start_rise
      |=> capturing && idx_q == '0 && !$past(cap_we))
      else $error("start pulse did not arm capture at index zero");

   a_carry_rise: assert property (@(posedge clk_i) disable iff (rst_i)
      shift_en && capturing && idx_q == line_len - 7'h02
      |=> carry_q && carry_cnt_q == 2'h1)
      else $error("carry not raised before last capture");

   a_load_copy: assert property (@(posedge clk_i) disable iff (rst_i)
      shift_en && sync2_q.load |=> drv_q == $past(line_q))
      else $error("load strobe did not copy line");

   a_ps_hiz: assert property (@(posedge clk_i) disable iff (rst_i)
      shift_en && sync2_q.power_save |=> hiz_q && !dac_q ##1 !dac_q)
      else $error("power save did not float outputs");

   a_fmt_hiz: assert property (@(posedge clk_i) disable iff (rst_i)
      fmt_chg |=> hiz_q)
      else $error("format change did not float outputs");

   a_skip_region: assert property (@(posedge clk_i) disable iff (rst_i)
      cap_we && !count_360 |-> pos < SKIP_FIRST || pos >= SKIP_END)
      else $error("short mode wrote a disabled position");

   a_binary_bits: assert property (@(posedge clk_i) disable iff (rst_i)
      fmt_bin |-> cap_val[CH_RED][MSB_BIT-1:0] == '0
                  && cap_val[CH_BLUE][MSB_BIT-1:0] == '0)
      else $error("binary capture kept low bits");

   a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_cyc_i && wb_stb_i && !ack_q |=> ack_q ##1 !ack_q)
      else $error("wishbone ack not a single pulse");

endmodule : tsdc_capture

// file: verification/tsdc_ctrl_model.sv
// Panel timing controller model: shift clock, pixel bus, start, load.
// Assumes the driver samples its pins through a synchroniser on clk_i.
`timescale 1ns/100ps
module tsdc_ctrl_model
   import tsdc_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              carry_i,
   output logic                   shift_clock_o,
   output logic [DATA_W-1:0]      red_o,
   output logic [DATA_W-1:0]      green_o,
   output logic [DATA_W-1:0]      blue_o,
   output logic                   start_o,
   output logic                   load_o,
   output logic                   invert_o,
   output logic                   power_save_o
);
   int carry_first;
   int carry_len;

   initial begin
      {shift_clock_o, start_o, load_o, invert_o, power_save_o} = 5'h00;
      {red_o, green_o, blue_o} = 18'h00000;
   end

   // Edges -2,-1 and n+1,n+2 carry junk data with no start
   task automatic run(input int n, input logic inv_pat, input logic ps);
      carry_first = -1;
      carry_len = 0;
      for (int e = -2; e <= n + 2; e++) begin
         @(posedge clk_i);
         shift_clock_o <= 1'b0;
         start_o <= (e == 0);
         load_o <= (e == n + 2);
         invert_o <= inv_pat & e[0];
         power_save_o <= ps;
         red_o <= e[5:0];
         green_o <= ~e[5:0];
         blue_o <= e[5:0] ^ 6'h2A;
         repeat (3) @(posedge clk_i);
         // Carry sampled just before the next rising shift edge
         if (carry_i === 1'b1) begin
            if (carry_first < 0) carry_first = e;
            carry_len++;
         end
         // slow shift clock, four clocks per phase
         @(posedge clk_i);
         shift_clock_o <= 1'b1;
         repeat (3) @(posedge clk_i);
      end
      @(posedge clk_i);
      shift_clock_o <= 1'b0;
      start_o <= 1'b0;
      load_o <= 1'b0;
      // Released bus shows the inverse, never the last value
      red_o <= ~red_o;
      green_o <= ~green_o;
      blue_o <= ~blue_o;
   endtask : run
endmodule : tsdc_ctrl_model

// file: verification/tft_source_driver_data_capture_test.sv
// Self-checking bench for the source driver capture block.
// Assumes tsdc_ctrl_model as the panel controller and a 50 MHz clock.
`timescale 1ns/100ps
module tft_source_driver_data_capture_test
   import tsdc_pkg::*;
;
   logic                          clk_i, rst_i, cyc, stb, we, ack, test_n;
   logic [3:0]                    adr;
   logic [31:0]                   wdat, rdat;
   logic [DATA_W-1:0]             red, green, blue;
   logic                          shclk, start, load, polarity_invert, ps, carry;
   logic                          r_in, r_out, r_oe, l_in, l_out, l_oe;
   logic [NUM_POS-1:0][DATA_W-1:0] red_drv, green_drv, blue_drv;
   logic [NUM_POS-1:0]            pos_en;
   logic                          hiz, dac, test_act, cur_dir;
   int                            fail_count, n_tests;

   assign r_in = r_oe ? r_out : (start & cur_dir);
   assign l_in = l_oe ? l_out : (start & ~cur_dir);
   assign carry = cur_dir ? l_out : r_out;

   tsdc_capture uut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .red_channel_bus_i(red),
      .green_channel_bus_i(green), .blue_channel_bus_i(blue),
      .shift_clock_i(shclk), .line_load_strobe_i(load),
      .polarity_invert_i(polarity_invert), .power_save_input_i(ps),
      .test_mode_n_i(test_n), .right_start_pulse_i(r_in),
      .right_start_pulse_o(r_out), .right_start_pulse_oe_o(r_oe),
      .left_start_pulse_i(l_in), .left_start_pulse_o(l_out),
      .left_start_pulse_oe_o(l_oe), .red_drive_outputs_o(red_drv),
      .green_drive_outputs_o(green_drv), .blue_drive_outputs_o(blue_drv),
      .pos_enable_o(pos_en), .drive_hiz_o(hiz), .dac_enable_o(dac),
      .test_active_o(test_act));

   tsdc_ctrl_model cm (
      .clk_i(clk_i), .carry_i(carry), .shift_clock_o(shclk), .red_o(red),
      .green_o(green), .blue_o(blue), .start_o(start), .load_o(load),
      .invert_o(polarity_invert), .power_save_o(ps));

   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end

   task automatic results;
      $display("TB: %0d checks, %0d errors", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : results

   task automatic check(input logic ok, input string msg);
      n_tests++;
      if (ok !== 1'b1) begin
         fail_count++;
         $display("Error at %0t: %s", $time, msg);
      end
   endtask : check

   task automatic wb(input logic w, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] q);
      int t;
      @(posedge clk_i);
      {cyc, stb, we, adr, wdat} <= {1'b1, 1'b1, w, a, d};
      t = 0;
      do begin
         @(posedge clk_i);
         t++;
      end while (ack !== 1'b1 && t < 20);
      if (ack !== 1'b1) begin
         check(1'b0, "bus answer missing");
         results();
      end
      q = rdat;
      {cyc, stb, we} <= 3'h0;
   endtask : wb

   // Gray keeps the code, binary keeps bit 5 only, after inversion
   function automatic logic [5:0] expv(logic [5:0] d, logic i, logic b);
      logic [5:0] v;
      v = d ^ {6{i}};
      return b ? (v & 6'h20) : v;
   endfunction : expv

   task automatic do_line(input logic [2:0] c, input logic ip, input logic p);
      int n, q;
      logic [31:0] r;
      logic [5:0] d;
      logic i, b;
      wb(1'b1, 4'h0, {29'h0, c}, r);
      cur_dir <= c[CTRL_DIR];
      b = c[CTRL_FORMAT];
      n = c[CTRL_COUNT] ? 120 : 108;
      cm.run(n, ip, p);
      repeat (4) @(posedge clk_i);
      check(l_oe === c[0] && r_oe === ~c[0], "start pin roles");
      check(cm.carry_first == n, "carry start cycle");
      check(cm.carry_len == 2, "carry length");
      wb(1'b0, 4'h4, 32'h0, r);
      check(r[2:0] === {p, 2'h0}, "status word");
      if (p) return;
      check(dac === ~b && hiz === 1'b0, "converter state");
      for (int k = 1; k <= n; k++) begin
         q = (!c[CTRL_COUNT] && k > 54) ? k + 11 : k - 1;
         if (!c[CTRL_DIR]) q = 119 - q;
         d = k[5:0];
         i = ip & k[0];
         check(red_drv[q] === expv(d, i, b), "red pixel");
         check(green_drv[q] === expv(~d, i, b), "green pixel");
         check(blue_drv[q] === expv(d ^ 6'h2A, i, b), "blue pixel");
      end
      for (int k = 0; k < NUM_POS; k++)
         check(pos_en[k] === (c[1] || k < 54 || k > 65), "enable");
   endtask : do_line

   task automatic t_regs;
      logic [31:0] q;
      wb(1'b0, 4'h0, 32'h0, q);
      check(q === 32'h00000003, "control reset value");
      wb(1'b1, 4'hC, 32'hFFFFFFFF, q);
      wb(1'b0, 4'h8, 32'h0, q);
      check(q === 32'h00000000, "unmapped read");
      wb(1'b0, 4'h0, 32'h0, q);
      check(q === 32'h00000003, "control kept");
   endtask : t_regs

   task automatic t_binary;
      logic [31:0] q;
      wb(1'b1, 4'h0, 32'h00000007, q);
      repeat (2) @(posedge clk_i);
      check(hiz === 1'b1, "float on format change");
      do_line(3'h7, 1'b1, 1'b0);
   endtask : t_binary

   task automatic t_power;
      do_line(3'h3, 1'b0, 1'b1);
      check(hiz === 1'b1 && dac === 1'b0, "power save");
   endtask : t_power

   task automatic t_test;
      test_n <= 1'b0;
      repeat (6) @(posedge clk_i);
      check(test_act === 1'b1, "test mode on");
      test_n <= 1'b1;
      repeat (6) @(posedge clk_i);
      check(test_act === 1'b0, "test mode off");
   endtask : t_test

   initial begin
      {fail_count, n_tests} = 0;
      {rst_i, test_n, cur_dir} = 3'h7;
      {cyc, stb, we, adr, wdat} = 39'h0;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      t_regs();
      do_line(3'h3, 1'b0, 1'b0);
      do_line(3'h0, 1'b1, 1'b0);
      t_binary();
      t_power();
      t_test();
      results();
   end

   initial begin
      repeat (100000) @(posedge clk_i);
      check(1'b0, "run limit reached");
      results();
   end
endmodule : tft_source_driver_data_capture_test
